// file: src/octal_registered_bus_transceiver.sv
/*
  eight-bit registered bus transceiver between bus a and bus b, with one
  storage register, one enable and one select per direction.
  assumes all control and bus pins are asynchronous to clk and that the
  surrounding wire logic resolves each bus from the enables.
*/
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RULE1] each storage register captures its source bus at its own clock rising edge, regardless of selects and enables.
// [RULE2] per direction, select low sends live bus data and select high sends that direction's stored word.
// [RULE3] changing a select never makes a decoding glitch on the output.
// [RULE4] bus b drives while the a-to-b enable is high, bus a drives while the active-low b-to-a enable is low.
// [RULE5] the two directions have separate registers and enables and work independently.
// [RULE6] with both selects live and both enables active each bus is driven from the other, holding the last value.
// [RULE7] the design builds either as a true or an inverting transceiver for live and stored data alike.
// [RULE8] the a side drives either three-state or pull-low only; the b side is always three-state.
// [RULE9] both enables high with both clocks rising stores a data in both registers and drives a onto b.
// [RULE10] both enables low with both clocks rising stores b data in both registers and drives b onto a.
// [RULE11] both enables low with b-to-a select low drives live b data onto a continuously.
// [RULE12] both enables high with a-to-b select low drives live a data onto b.
// [RULE13] capture is never gated by the enables; only driving depends on them.
// [RULE14] to load both registers from one bus with stored selects, the outside staggers the two clocks.
// [RULE15] with live selects, the outside may pulse both clocks together.
// [RULE16] a register without a rising clock keeps its contents; the code still clears both registers to STORED_RESET_VALUE on rst.
// [RULE17] a-to-b enable low and b-to-a enable high isolates both sides while clocks still load.
module octal_registered_bus_transceiver
  import bus_transceiver_pkg::*;
#(
  parameter int       WIDTH       = `BUS_WIDTH,
  parameter bit       INVERTING   = `VARIANT_TRUE,
  parameter bit       A_OPEN_DRAIN = `A_SIDE_THREE_STATE
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              a_to_b_output_enable,
  input  wire logic              b_to_a_output_enable_n,
  input  wire logic              a_to_b_source_select,
  input  wire logic              b_to_a_source_select,
  input  wire logic              a_register_clock,
  input  wire logic              b_register_clock,
  input  wire logic [WIDTH-1:0]  a_in,
  output var  logic [WIDTH-1:0]  a_out,
  output var  logic [WIDTH-1:0]  a_oe,
  input  wire logic [WIDTH-1:0]  b_in,
  output var  logic [WIDTH-1:0]  b_out,
  output var  logic [WIDTH-1:0]  b_oe
);

  if (WIDTH != `BUS_WIDTH) begin : g_width_check
    $error("WIDTH must equal the bus word width");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for buses and controls

  bus_word_type a_meta;
  bus_word_type a_sync;
  bus_word_type b_meta;
  bus_word_type b_sync;
  logic [1:0]   enable_meta;
  logic [1:0]   enable_sync;
  logic [1:0]   select_meta;
  logic [1:0]   select_sync;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_meta <= `DRIVE_RESET_VALUE;
      a_sync <= `DRIVE_RESET_VALUE;
    end else begin
      a_meta <= a_in;
      a_sync <= a_meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_meta <= `DRIVE_RESET_VALUE;
      b_sync <= `DRIVE_RESET_VALUE;
    end else begin
      b_meta <= b_in;
      b_sync <= b_meta;
    end
  end

  // reset values: both enables inactive, the b-to-a one being active low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_meta <= 2'h2;
      enable_sync <= 2'h2;
    end else begin
      enable_meta <= {b_to_a_output_enable_n, a_to_b_output_enable};
      enable_sync <= enable_meta;
    end
  end

  // reset values: both selects live
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      select_meta <= 2'h0;
      select_sync <= 2'h0;
    end else begin
      select_meta <= {b_to_a_source_select, a_to_b_source_select};
      select_sync <= select_meta;
    end
  end

  logic              a_to_b_enable;
  logic              b_to_a_enable;
  source_select_type a_to_b_source;
  source_select_type b_to_a_source;

  assign a_to_b_enable  = enable_sync[0];                   // [RULE4]
  assign b_to_a_enable  = ~enable_sync[1];                  // [RULE4]
  assign a_to_b_source  = source_select_type'(select_sync[0]);
  assign b_to_a_source  = source_select_type'(select_sync[1]);

  //////////////////////////////////////////////////////////////////////////////
  // storage paths, one per direction

  storage_path_if a_path ();
  storage_path_if b_path ();

  assign a_path.source = a_sync;                            // [RULE13]
  assign b_path.source = b_sync;                            // [RULE13]

  storage_path u_a_store (                                  // [RULE5]
    .clk            (clk),
    .rst            (rst),
    .register_clock (a_register_clock),
    .port_side      (a_path.path)
  );

  storage_path u_b_store (                                  // [RULE5]
    .clk            (clk),
    .rst            (rst),
    .register_clock (b_register_clock),
    .port_side      (b_path.path)
  );

  //////////////////////////////////////////////////////////////////////////////
  // source selection and polarity

  bus_word_type invert_mask;
  bus_word_type next_b_word;
  bus_word_type next_a_word;

  assign invert_mask = INVERTING ? {WIDTH{1'b1}} : {WIDTH{1'b0}};   // [RULE7]

  always_comb begin
    unique case (a_to_b_source)
      SOURCE_LIVE:   next_b_word = a_sync ^ invert_mask;            // [RULE2] [RULE12] [RULE9]
      SOURCE_STORED: next_b_word = a_path.stored ^ invert_mask;     // [RULE2]
    endcase
  end

  always_comb begin
    unique case (b_to_a_source)
      SOURCE_LIVE:   next_a_word = b_sync ^ invert_mask;            // [RULE2] [RULE11] [RULE10]
      SOURCE_STORED: next_a_word = b_path.stored ^ invert_mask;     // [RULE2]
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // output drivers, registered so a select change cannot glitch

  bus_word_type next_a_out;
  bus_word_type next_a_oe;

  // the pull-low build enables a bit only where the word is zero
  always_comb begin
    if (A_OPEN_DRAIN) begin
      next_a_out = {WIDTH{1'b0}};                           // [RULE8]
      next_a_oe  = {WIDTH{b_to_a_enable}} & ~next_a_word;   // [RULE8]
    end else begin
      next_a_out = next_a_word;
      next_a_oe  = {WIDTH{b_to_a_enable}};
    end
  end

  // b side is three-state in every build
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_out <= `DRIVE_RESET_VALUE;
    end else begin
      b_out <= next_b_word;                                 // [RULE3]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_oe <= `DRIVE_RESET_VALUE;
    end else begin
      b_oe <= {WIDTH{a_to_b_enable}};                       // [RULE4] [RULE17]
    end
  end

  // both enables active with live selects closes the loop a->b->a [RULE6]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_out <= `DRIVE_RESET_VALUE;
    end else begin
      a_out <= next_a_out;                                  // [RULE3]
    end
  end

  // a disabled side only listens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_oe <= `DRIVE_RESET_VALUE;
    end else begin
      a_oe <= next_a_oe;                                    // [RULE4] [RULE17]
    end
  end

endmodule // octal_registered_bus_transceiver

`default_nettype wire

// file: shared/bus_transceiver_defines.svh
/*
  constants for the registered octal bus transceiver: bus width, reset values,
  variant selections and the clk period in ns.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef BUS_TRANSCEIVER_DEFINES_SVH
`define BUS_TRANSCEIVER_DEFINES_SVH

`define BUS_WIDTH          8
`define STORED_RESET_VALUE 8'h00
`define DRIVE_RESET_VALUE  8'h00
`define VARIANT_TRUE       1'b0
`define VARIANT_INVERTING  1'b1
`define A_SIDE_THREE_STATE 1'b0
`define A_SIDE_OPEN_DRAIN  1'b1
`define CLK_PERIOD_NS      25

`endif

// file: shared/bus_transceiver_pkg.sv
/*
  types shared by the transceiver top and its storage path module.
  assumes the defines header is on the include path.
*/
`include "bus_transceiver_defines.svh"

package bus_transceiver_pkg;

  typedef logic [`BUS_WIDTH-1:0] bus_word_type;

  typedef enum logic {
    SOURCE_LIVE   = 1'b0,
    SOURCE_STORED = 1'b1
  } source_select_type;

endpackage

// file: shared/storage_path_if.sv
/*
  carrier between the transceiver top and one storage path: the synchronised
  source bus word going in and the stored word coming back.
  assumes both ends run on the same clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface storage_path_if;
  import bus_transceiver_pkg::*;

  bus_word_type source;
  bus_word_type stored;
  logic         captured;

  modport path (
    input  source,
    output stored,
    output captured
  );

  modport owner (
    output source,
    input  stored,
    input  captured
  );
endinterface

`default_nettype wire

// file: src/storage_path.sv
/*
  one direction's storage register: synchronises the register clock pin,
  finds its rising edge and captures the source word on it.
  assumes source is already synchronised to clk by the owner.
*/
`timescale 1ns/1ps
`default_nettype none

module storage_path
  import bus_transceiver_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  register_clock,
  storage_path_if.path port_side
);

  //////////////////////////////////////////////////////////////////////////////
  // register clock pin synchroniser and edge finder

  logic clock_meta;
  logic clock_sync;
  logic clock_last;
  logic rising;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_meta <= 1'b0;
      clock_sync <= 1'b0;
    end else begin
      clock_meta <= register_clock;
      clock_sync <= clock_meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_last <= 1'b0;
    end else begin
      clock_last <= clock_sync;
    end
  end

  assign rising = clock_sync & ~clock_last;

  //////////////////////////////////////////////////////////////////////////////
  // stored word

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_side.stored <= `STORED_RESET_VALUE;
    end else if (rising) begin
      port_side.stored <= port_side.source;   // [RULE1] [RULE13]
    end
  end                                         // [RULE16]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_side.captured <= 1'b0;
    end else begin
      port_side.captured <= rising;
    end
  end

endmodule // storage_path

`default_nettype wire

// file: dv/bus_transceiver_checker.sv
/* checker: port assertions for the transceiver top.
   assumes pins reach the outputs within 3 or 4 clk. */
`timescale 1ns/1ps
`default_nettype none
module bus_transceiver_checker #(
  parameter int WIDTH        = 8,
  parameter bit INVERTING    = 1'b0,
  parameter bit A_OPEN_DRAIN = 1'b0
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             a_to_b_output_enable,
  input wire logic             b_to_a_output_enable_n,
  input wire logic             a_to_b_source_select,
  input wire logic             b_to_a_source_select,
  input wire logic             a_register_clock,
  input wire logic             b_register_clock,
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] a_out,
  input wire logic [WIDTH-1:0] a_oe,
  input wire logic [WIDTH-1:0] b_in,
  input wire logic [WIDTH-1:0] b_out,
  input wire logic [WIDTH-1:0] b_oe
);
  logic [2*WIDTH+3:0] d1, d2, d3, d4;
  logic [3:0]         age, hc;
  logic [WIDTH-1:0]   a3, b3, inv;
  logic               e3, n3, sa3, sb3, ctl, all_s;
  assign {e3, n3, sa3, sb3, a3, b3} = d3;
  assign inv = {WIDTH{INVERTING}};
  assign ctl = age[3] && d3[2*WIDTH+3:2*WIDTH] == d4[2*WIDTH+3:2*WIDTH];
  assign all_s = ctl && d3 == d4;
  always_ff @(posedge clk) begin
    d1 <= {a_to_b_output_enable, b_to_a_output_enable_n, a_to_b_source_select, b_to_a_source_select, a_in, b_in};
    d2 <= d1;
    d3 <= d2;
    d4 <= d3;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) age <= 4'h0;
    else if (!age[3]) age <= age + 4'h1;
  end
  // cycles since either register clock last moved
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hc <= 4'h0;
    else if ($changed(a_register_clock) || $changed(b_register_clock)) hc <= 4'h0;
    else if (hc != 4'hf) hc <= hc + 4'h1;
  end
  //////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_b_en; ctl |-> b_oe == {WIDTH{e3}}; endproperty
  a_b_en: assert property (p_b_en) else $error("b enable wrong");
  property p_a_en; ctl && !A_OPEN_DRAIN |-> a_oe == {WIDTH{!n3}}; endproperty
  a_a_en: assert property (p_a_en) else $error("a enable wrong");
  property p_live_b; all_s && e3 && !sa3 |-> b_out == (a3 ^ inv); endproperty
  a_live_b: assert property (p_live_b) else $error("live b wrong");
  property p_live_a; all_s && !n3 && !sb3 && !A_OPEN_DRAIN |-> a_out == (b3 ^ inv); endproperty
  a_live_a: assert property (p_live_a) else $error("live a wrong");
  property p_isolate; ctl && !e3 && n3 |-> (a_oe | b_oe) == '0; endproperty
  a_isolate: assert property (p_isolate) else $error("not isolated");
  property p_loop; ctl && e3 && !n3 && !A_OPEN_DRAIN |-> (a_oe & b_oe) == '1; endproperty
  a_loop: assert property (p_loop) else $error("loop not driven");
  property p_hold_b; (ctl && e3 && sa3 && hc > 4'h9) ##1 ctl |-> $stable(b_out); endproperty
  a_hold_b: assert property (p_hold_b) else $error("stored b moved");
  property p_hold_a; (ctl && !n3 && sb3 && hc > 4'h9) ##1 ctl |-> $stable(a_out); endproperty
  a_hold_a: assert property (p_hold_a) else $error("stored a moved");
  c_isolate: cover property (ctl && !e3 && n3);
  c_loop: cover property (all_s && e3 && !n3 && !sa3 && !sb3);
  c_stored: cover property (ctl && e3 && sa3 && hc > 4'h9);
endmodule // bus_transceiver_checker
bind octal_registered_bus_transceiver bus_transceiver_checker #(
  .WIDTH(WIDTH), .INVERTING(INVERTING), .A_OPEN_DRAIN(A_OPEN_DRAIN)) chk (
  .clk, .rst, .a_to_b_output_enable, .b_to_a_output_enable_n, .a_to_b_source_select,
  .b_to_a_source_select, .a_register_clock, .b_register_clock, .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe);
`default_nettype wire

// file: dv/bus_partner_model.sv
/* far side of both buses: drives a bus when told, else it floats.
   assumes the dut outputs change on clk. */
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model #(parameter int WIDTH = 8) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] a_out,
  input  wire logic [WIDTH-1:0] a_oe,
  input  wire logic [WIDTH-1:0] b_out,
  input  wire logic [WIDTH-1:0] b_oe,
  input  wire logic [WIDTH-1:0] a_drv,
  input  wire logic             a_drv_en,
  input  wire logic [WIDTH-1:0] b_drv,
  input  wire logic             b_drv_en,
  output logic      [WIDTH-1:0] a_in,
  output logic      [WIDTH-1:0] b_in
);
  logic [WIDTH-1:0] noise = '0;
  always_ff @(posedge clk) noise <= ~noise;
  // dut first, then this side, else a float that toggles every cycle
  assign a_in = a_oe & a_out | ~a_oe & (a_drv_en ? a_drv : noise);
  assign b_in = b_oe & b_out | ~b_oe & (b_drv_en ? b_drv : noise);
endmodule // bus_partner_model
`default_nettype wire

// file: dv/octal_registered_bus_transceiver_bench.sv
/* bench: live cases from a table, then store and loop tests.
   assumes the partner model and the checker bind are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module octal_registered_bus_transceiver_bench;
  import bus_transceiver_pkg::*;
  // c is {a-to-b enable, b-to-a enable low, a-to-b select, b-to-a select}
  typedef struct {
    logic [3:0]   c;
    bus_word_type a, b;
    logic [1:0]   dv;
    bus_word_type xaoe, xa, xboe, xb;
  } row_type;
  row_type rows [4] = '{
    '{4'h4, 8'h3c, 8'hc3, 2'h3, 8'h00, 8'h00, 8'h00, 8'h00},
    '{4'hc, 8'h3c, 8'h00, 2'h2, 8'h00, 8'h00, 8'hff, 8'hc3},
    '{4'hc, 8'h00, 8'h00, 2'h2, 8'h00, 8'h00, 8'hff, 8'hff},
    '{4'h0, 8'h00, 8'h81, 2'h1, 8'hff, 8'h7e, 8'h00, 8'h00}};
  logic         clk, rst, clk_a, clk_b;
  logic [3:0]   c;
  logic [1:0]   dv;
  bus_word_type a_drv, b_drv, a_in, a_out, a_oe, b_in, b_out, b_oe;
  bus_word_type od_a_out, od_a_oe, od_b_out, od_b_oe;
  int           failures = 0, n_tests = 0, cycles = 0;
  octal_registered_bus_transceiver #(.INVERTING(1'b1)) dut (.clk, .rst, .a_to_b_output_enable(c[3]),
    .b_to_a_output_enable_n(c[2]), .a_to_b_source_select(c[1]), .b_to_a_source_select(c[0]),
    .a_register_clock(clk_a), .b_register_clock(clk_b), .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe);
  bus_partner_model partner (.clk, .a_out, .a_oe, .b_out, .b_oe, .a_drv, .a_drv_en(dv[1]),
    .b_drv, .b_drv_en(dv[0]), .a_in, .b_in);
  // true, pull-low build listening to the same buses
  octal_registered_bus_transceiver #(.INVERTING(1'b0), .A_OPEN_DRAIN(1'b1)) dut_pull_low (.clk, .rst,
    .a_to_b_output_enable(c[3]), .b_to_a_output_enable_n(c[2]), .a_to_b_source_select(c[1]),
    .b_to_a_source_select(c[0]), .a_register_clock(clk_a), .b_register_clock(clk_b), .a_in,
    .a_out(od_a_out), .a_oe(od_a_oe), .b_in, .b_out(od_b_out), .b_oe(od_b_oe));
  //////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input bus_word_type got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic drive(input logic [3:0] k, input bus_word_type a, b, input logic [1:0] d);
    @(posedge clk);
    c <= k;
    a_drv <= a;
    b_drv <= b;
    dv <= d;
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse(input logic [1:0] k);
    @(posedge clk);
    {clk_a, clk_b} <= k;
    repeat (4) @(posedge clk);
    {clk_a, clk_b} <= 2'b00;
    repeat (8) @(posedge clk);
  endtask
  // load, disturb both buses with idle clocks, then show both stored words
  task automatic store_show(input logic [3:0] k, input bus_word_type a, b, input logic [1:0] d,
                            input bit stag, input bus_word_type xa, xb);
    drive(k, a, b, d);
    if (stag) begin
      pulse(2'b10);
      pulse(2'b01);
    end else pulse(2'b11);
    drive(4'h4, 8'h0f, 8'hf0, 2'h3);
    drive(4'hb, 8'h00, 8'h00, 2'h0);
    check(a_out, xa, "stored to a");
    check(b_out, xb, "stored to b");
    check(od_b_out, ~xb, "true stored to b");
    $display("store test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    rst = 1'b1;
    {c, clk_a, clk_b, dv, a_drv, b_drv} = '0;
    repeat (12) @(posedge clk);
    check(a_oe | b_oe, 8'h00, "reset drive");
    $display("power-up reset done");
    rst <= 1'b0;
    foreach (rows[i]) begin
      drive(rows[i].c, rows[i].a, rows[i].b, rows[i].dv);
      check(a_oe, rows[i].xaoe, "a_oe");
      check(a_out & a_oe, rows[i].xa, "a_out");
      check(b_oe, rows[i].xboe, "b_oe");
      check(b_out & b_oe, rows[i].xb, "b_out");
      check(od_b_out & od_b_oe, rows[i].xb ^ rows[i].xboe, "true b_out");
      check(od_a_oe, rows[i].xa, "pull-low a_oe");
      check(od_a_out, 8'h00, "pull-low a_out");
      $display("row %0d done", i);
    end
    store_show(4'h4, 8'ha5, 8'h5a, 2'h3, 1'b0, 8'ha5, 8'h5a);
    store_show(4'he, 8'h96, 8'h00, 2'h2, 1'b1, 8'h96, 8'h69);
    store_show(4'h0, 8'h00, 8'h3a, 2'h1, 1'b0, 8'hc5, 8'h3a);
    drive(4'hc, 8'he7, 8'h00, 2'h2);
    drive(4'h8, 8'he7, 8'h00, 2'h2);
    drive(4'h8, 8'h00, 8'h00, 2'h0);
    check(a_out, 8'he7, "loop a");
    check(b_out, 8'h18, "loop b");
    $display("loop test done");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    check(a_oe | b_oe, 8'h00, "mid reset drive");
    rst <= 1'b0;
    drive(4'hb, 8'h00, 8'h00, 2'h0);
    check(a_out, 8'hff, "cleared store to a");
    check(b_out, 8'hff, "cleared store to b");
    $display("mid reset test done");
    close_out;
  end
endmodule // octal_registered_bus_transceiver_bench
`default_nettype wire
